//--- hw/status_word_defs.vh
// constants for the serial status word reporter
// assumes 8-bit register data and byte addresses
`ifndef STATUS_WORD_DEFS_VH
`define STATUS_WORD_DEFS_VH

// register offsets
`define OFS_CFG_B        8'h01
`define OFS_CFG_C        8'h10
`define OFS_IF_STAT      8'h11
`define OFS_DEV_STAT     8'h14
`define OFS_INSTR_HI     8'h18
`define OFS_INSTR_LO     8'h19

// config B fields
`define CFGB_SHORT       7
// config C fields
`define CFGC_STRICT      5
`define CFGC_SEND        4
`define CFGC_SWRST       0

// reset values
`define CFG_B_RST        8'h00
`define CFG_C_RST        8'h20

// interface status fields
`define IFS_NOT_READY    7
`define IFS_CLK_COUNT    4
`define IFS_CHECKSUM     3
`define IFS_RO_WRITE     2
`define IFS_PARTIAL      1
`define IFS_BAD_ADDR     0
`define IFS_USED_MASK    8'h9F

// device status fields
`define DVS_FIFO_FULL    7
`define DVS_READ_DONE    6
`define DVS_UPPER        5
`define DVS_LOWER        4
`define DVS_ANA_POR      3
`define DVS_CONV_FAULT   2
`define DVS_ROM_FAIL     1
`define DVS_POR          0

// instruction phase lengths in serial clocks
`define LEN_LONG         5'd16
`define LEN_SHORT        5'd8

`endif

//--- hw/status_word_reporter.v
// serial status word reporter with its register port
// assumes SCLK, CS_N, SDI come from another domain; SPI mode 0
//
// What this block does
// - long word 16 bits; bits 15,14 zero; bit 13 fifo full
// - long bit 12 carries fifo readout done flag
// - long bits 11,10 carry upper and lower limit event flags
// - long bit 9 carries conversion fault flag
// - long bit 8 carries rom integrity failure flag
// - long bit 7 carries analog power-up event flag
// - long bit 6 carries power-on-reset flag until cleared
// - bit 5 is not-ready error, transaction before init done
// - bit 4 is clock count error, wrong clock count in frame
// - bit 3 is checksum error, missing or mismatched checksum
// - bit 2 is write to read-only register error
// - bit 1 is partial multibyte access error, strict mode only
// - bit 0 is invalid address error
// - short word 8 bits with bit 7 zero
// - short bit 6 carries power-on-reset flag
// - short bits 5..0 equal long bits 5..0
// - word shifted out on serial output during instruction phase
// - sending off after reset until enable bit set
// - msb first; length follows instruction length selection
`include "status_word_defs.vh"

module status_word_reporter (
  input  wire       CLK_SYS,
  input  wire       RESET_N,
  // register port
  input  wire [7:0] ADDR,
  input  wire [7:0] WDATA,
  input  wire       WR,
  input  wire       RD,
  output reg  [7:0] RDATA,
  // serial pins
  input  wire       SCLK,
  input  wire       CS_N,
  input  wire       SDI,
  output reg        SDO,
  output reg        SDO_OE,
  // device flags, levels on CLK_SYS
  input  wire       FIFO_FULL,
  input  wire       FIFO_READ_DONE,
  input  wire       UPPER_LIMIT_EVENT,
  input  wire       LOWER_LIMIT_EVENT,
  input  wire       CONVERSION_FAULT,
  input  wire       ROM_INTEGRITY_FAIL,
  // one-cycle event pulses on CLK_SYS
  input  wire       ANALOG_POWERUP_EVT,
  input  wire       CHECKSUM_FAULT_EVT,
  input  wire       READONLY_WRITE_FAULT_EVT,
  input  wire       PARTIAL_ACCESS_EVT,
  input  wire       BAD_ADDRESS_EVT,
  // digital initialization finished, level
  input  wire       INIT_DONE,
  // pulse when software reset requested
  output reg        SOFT_RESET,
  output wire       STRICT_ACCESS
);

  // synchronisers
  reg [2:0]  sclk_s_r;
  reg [2:0]  cs_s_r;
  reg [1:0]  sdi_s_r;

  // registers
  reg [7:0]  cfg_b_r;
  reg [7:0]  cfg_c_r;
  reg [7:0]  if_stat_r;
  reg [7:0]  if_stat_nxt;
  reg        por_r;
  reg        ana_por_r;
  reg        por_nxt;
  reg        ana_por_nxt;

  // serial state
  reg [15:0] shift_r;
  reg [15:0] instr_r;
  reg [15:0] instr_hold_r;
  reg [4:0]  len_r;
  reg [5:0]  bit_cnt_r;
  reg        sending_r;
  reg        in_frame_r;

  wire       sclk_rise;
  wire       sclk_fall;
  wire       cs_fall;
  wire       cs_rise;
  wire       sdi_in;
  wire       clk_cnt_bad;
  wire       not_ready_hit;
  wire [7:0] dev_stat;
  wire [7:0] clr_mask;
  wire       wr_if_stat;
  wire       wr_dev_stat;
  wire [15:0] word_long;
  wire [7:0]  word_short;

  // live plus sticky device status
  assign dev_stat = {FIFO_FULL, FIFO_READ_DONE,
                     UPPER_LIMIT_EVENT, LOWER_LIMIT_EVENT,
                     ana_por_r, CONVERSION_FAULT,
                     ROM_INTEGRITY_FAIL, por_r};

  assign STRICT_ACCESS = cfg_c_r[`CFGC_STRICT];

  // ---------------------------------------------------------------
  // pin synchronisers; edges use stages 2 and 3 only
  always @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      sclk_s_r <= 3'h0;
      cs_s_r   <= 3'h7;
      sdi_s_r  <= 2'h0;
    end else begin
      sclk_s_r <= {sclk_s_r[1:0], SCLK};
      cs_s_r   <= {cs_s_r[1:0], CS_N};
      sdi_s_r  <= {sdi_s_r[0], SDI};
    end
  end

  assign sclk_rise = sclk_s_r[1] & ~sclk_s_r[2];
  assign sclk_fall = ~sclk_s_r[1] & sclk_s_r[2];
  assign cs_fall   = ~cs_s_r[1] & cs_s_r[2];
  assign cs_rise   = cs_s_r[1] & ~cs_s_r[2];
  assign sdi_in    = sdi_s_r[1];

  // ---------------------------------------------------------------
  // status word assembly
  // long word top bits
  assign word_long = {2'b00,
                      dev_stat[`DVS_FIFO_FULL],
                      dev_stat[`DVS_READ_DONE],
                      dev_stat[`DVS_UPPER],
                      dev_stat[`DVS_LOWER],
                      dev_stat[`DVS_CONV_FAULT],
                      dev_stat[`DVS_ROM_FAIL],
                      dev_stat[`DVS_ANA_POR],
                      dev_stat[`DVS_POR],
                      low_flags(if_stat_r)};

  assign word_short = {1'b0, dev_stat[`DVS_POR],
                       low_flags(if_stat_r)};

  // packs interface status into the six-bit error field
  function [5:0] low_flags;
    input [7:0] st;
    begin
      low_flags = {st[`IFS_NOT_READY], st[`IFS_CLK_COUNT],
                   st[`IFS_CHECKSUM], st[`IFS_RO_WRITE],
                   st[`IFS_PARTIAL], st[`IFS_BAD_ADDR]};
    end
  endfunction

  // ---------------------------------------------------------------
  // serial frame engine
  always @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      shift_r      <= 16'h0000;
      instr_r      <= 16'h0000;
      instr_hold_r <= 16'h0000;
      len_r        <= `LEN_LONG;
      bit_cnt_r    <= 6'h00;
      sending_r    <= 1'b0;
      in_frame_r   <= 1'b0;
      SDO          <= 1'b0;
      SDO_OE       <= 1'b0;
    end else if (cs_fall) begin
      // new frame: reload counters, capture the word
      in_frame_r <= 1'b1;
      bit_cnt_r  <= 6'h00;
      instr_r    <= 16'h0000;
      if (cfg_b_r[`CFGB_SHORT]) begin
        len_r   <= `LEN_SHORT;
        shift_r <= {word_short, 8'h00};
      end else begin
        len_r   <= `LEN_LONG;
        shift_r <= word_long;
      end
      sending_r <= cfg_c_r[`CFGC_SEND];
      SDO_OE    <= cfg_c_r[`CFGC_SEND];
      SDO       <= cfg_b_r[`CFGB_SHORT] ? word_short[7]
                                         : word_long[15];
    end else if (cs_rise) begin
      // frame end always releases the line
      in_frame_r <= 1'b0;
      sending_r  <= 1'b0;
      SDO_OE     <= 1'b0;
      SDO        <= 1'b0;
    end else if (in_frame_r) begin
      if (sclk_rise) begin
        // count saturates so a runaway frame cannot wrap
        if (bit_cnt_r != 6'h3F)
          bit_cnt_r <= bit_cnt_r + 6'h01;
        if (bit_cnt_r < {1'b0, len_r}) begin
          // instruction enters msb first
          instr_r <= {instr_r[14:0], sdi_in};
        end
        if (bit_cnt_r + 6'h01 == {1'b0, len_r}) begin
          // keep the finished instruction for readback
          instr_hold_r <= (len_r == `LEN_SHORT) ?
                          {8'h00, instr_r[6:0], sdi_in} :
                          {instr_r[14:0], sdi_in};
        end
      end
      if (sclk_fall && sending_r) begin
        // next bit after each falling edge
        if (bit_cnt_r < {1'b0, len_r}) begin
          shift_r <= {shift_r[14:0], 1'b0};
          SDO     <= shift_r[14];
        end else begin
          // instruction phase over, release line
          sending_r <= 1'b0;
          SDO_OE    <= 1'b0;
          SDO       <= 1'b0;
        end
      end
    end
  end

  // judged at frame end, so cut frames count too
  // frame must be a whole number of bytes
  assign clk_cnt_bad = cs_rise & in_frame_r &
                       ((bit_cnt_r[2:0] != 3'h0) ||
                        (bit_cnt_r < {1'b0, len_r}));

  assign not_ready_hit = cs_fall & ~INIT_DONE;

  // ---------------------------------------------------------------
  // register port decode
  assign wr_if_stat  = WR && (ADDR == `OFS_IF_STAT);
  assign wr_dev_stat = WR && (ADDR == `OFS_DEV_STAT);
  assign clr_mask    = wr_if_stat ? (WDATA & `IFS_USED_MASK)
                                  : 8'h00;

  // sticky flags; a set in the clearing cycle wins
  always @* begin
    if_stat_nxt = if_stat_r & ~clr_mask;
    if (not_ready_hit)
      if_stat_nxt[`IFS_NOT_READY] = 1'b1;
    if (clk_cnt_bad)
      if_stat_nxt[`IFS_CLK_COUNT] = 1'b1;
    if (CHECKSUM_FAULT_EVT)
      if_stat_nxt[`IFS_CHECKSUM] = 1'b1;
    if (READONLY_WRITE_FAULT_EVT)
      if_stat_nxt[`IFS_RO_WRITE] = 1'b1;
    if (PARTIAL_ACCESS_EVT && cfg_c_r[`CFGC_STRICT])
      if_stat_nxt[`IFS_PARTIAL] = 1'b1;
    if (BAD_ADDRESS_EVT)
      if_stat_nxt[`IFS_BAD_ADDR] = 1'b1;
  end

  // power-on flags: write 1 clears, events set
  always @* begin
    por_nxt     = por_r;
    ana_por_nxt = ana_por_r;
    if (wr_dev_stat && WDATA[`DVS_POR])
      por_nxt = 1'b0;
    if (wr_dev_stat && WDATA[`DVS_ANA_POR])
      ana_por_nxt = 1'b0;
    if (SOFT_RESET)
      por_nxt = 1'b1;
    if (ANALOG_POWERUP_EVT || SOFT_RESET)
      ana_por_nxt = 1'b1;
  end

  always @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      cfg_b_r    <= `CFG_B_RST;
      cfg_c_r    <= `CFG_C_RST;
      if_stat_r  <= 8'h00;
      por_r      <= 1'b1;
      ana_por_r  <= 1'b1;
      SOFT_RESET <= 1'b0;
    end else begin
      if_stat_r  <= if_stat_nxt;
      por_r      <= por_nxt;
      ana_por_r  <= ana_por_nxt;
      SOFT_RESET <= 1'b0;
      // only the short instruction bit is kept
      if (WR && ADDR == `OFS_CFG_B)
        cfg_b_r <= WDATA & 8'h80;
      if (WR && ADDR == `OFS_CFG_C) begin
        if (WDATA[`CFGC_SWRST]) begin
          cfg_c_r    <= `CFG_C_RST;
          cfg_b_r    <= `CFG_B_RST;
          SOFT_RESET <= 1'b1;
        end else begin
          // strict and send bits only
          cfg_c_r <= WDATA & 8'h30;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // read data, one cycle after the strobe
  always @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      RDATA <= 8'h00;
    end else if (RD) begin
      case (ADDR)
        `OFS_CFG_B:    RDATA <= cfg_b_r;
        `OFS_CFG_C:    RDATA <= cfg_c_r;
        `OFS_IF_STAT:  RDATA <= if_stat_r;
        `OFS_DEV_STAT: RDATA <= dev_stat;
        `OFS_INSTR_HI: RDATA <= instr_hold_r[15:8];
        `OFS_INSTR_LO: RDATA <= instr_hold_r[7:0];
        default:       RDATA <= 8'h00;
      endcase
    end else begin
      // zero outside the answer cycle
      RDATA <= 8'h00;
    end
  end

endmodule // status_word_reporter

//--- tb/status_word_checker.sv
// port assertions for the status word reporter
// bound into status_word_reporter at the foot
module status_word_checker (
  input wire logic       CLK_SYS,
  input wire logic       RESET_N,
  input wire logic [7:0] ADDR,
  input wire logic       WR,
  input wire logic       RD,
  input wire logic [7:0] RDATA,
  input wire logic       CS_N,
  input wire logic       SDO,
  input wire logic       SDO_OE,
  input wire logic       SOFT_RESET
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge CLK_SYS);
  endclocking
  default disable iff (!RESET_N);
  sequence oe_rising;
    !SDO_OE ##1 SDO_OE;
  endsequence
  a_reset_quiet: assert property ($rose(RESET_N) |-> !SDO_OE && !SDO)
    else $error("serial output active after reset");
  a_rdata_idle: assert property (!$past(RD) |-> RDATA == 8'h00)
    else $error("read data without read");
  a_sdo_idle: assert property (!SDO_OE |-> !SDO)
    else $error("data while output disabled");
  a_oe_late: assert property ($fell(CS_N) |-> !SDO_OE [*2])
    else $error("output before frame start seen");
  a_oe_in_frame: assert property (oe_rising |->
    !CS_N && !$past(CS_N) && !$past(CS_N, 2))
    else $error("output enabled outside frame");
  a_oe_release: assert property (CS_N [*4] |=> !SDO_OE)
    else $error("output held after frame end");
  a_soft_pulse: assert property (SOFT_RESET |=> !SOFT_RESET)
    else $error("soft reset pulse too long");
  a_soft_cause: assert property ($rose(SOFT_RESET) |->
    $past(WR) && $past(ADDR) == 8'h10)
    else $error("soft reset without write");
endmodule // status_word_checker

bind status_word_reporter status_word_checker chk (.CLK_SYS(CLK_SYS),
  .RESET_N(RESET_N), .ADDR(ADDR), .WR(WR), .RD(RD), .RDATA(RDATA),
  .CS_N(CS_N), .SDO(SDO), .SDO_OE(SDO_OE), .SOFT_RESET(SOFT_RESET));

//--- tb/spi_host_model.sv
// host model: runs serial frames, captures the status word
// bench calls frame(); clock idles low, 400 ns period
module spi_host_model (
  output logic      SCLK,
  output logic      CS_N,
  output logic      SDI,
  input  wire logic SDO,
  input  wire logic SDO_OE
);
  timeunit 1ns;
  timeprecision 1ns;
  logic oe_seen = 1'b0;
  initial begin
    SCLK = 1'b0;
    CS_N = 1'b1;
    SDI = 1'b0;
  end
  // pins move 12 ns off the system clock edges; instruction d msb first
  task frame(input int n, input logic [15:0] d, output logic [15:0] w);
    w = 16'h0000;
    oe_seen = 1'b0;
    #12 CS_N = 1'b0;
    #200;
    for (int i = 0; i < n; i++) begin
      SDI = d[n-1-i];
      #200 SCLK = 1'b1;
      w = {w[14:0], SDO_OE ? SDO : 1'bx};
      oe_seen |= SDO_OE;
      #200 SCLK = 1'b0;
    end
    #200 CS_N = 1'b1;
    SDI = 1'b0;
    #388;
  endtask
endmodule // spi_host_model

//--- tb/spi_status_word_reporter_test.sv
// bench for the status word reporter
// assumes the host model and checker are compiled alongside
module spi_status_word_reporter_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [7:0]  wdata = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        init = 1'b0;
  logic [5:0]  lv = 6'h00;
  logic [4:0]  ev = 5'h00;
  logic [15:0] w;
  logic [27:0] rows [13] = '{28'h4002000, 28'h2001000, 28'h1000800,
    28'h0800400, 28'h0400200, 28'h0200100, 28'h0100080, 28'h0080008,
    28'h0040004, 28'h0020002, 28'h0010001, 28'hFE90009, 28'h7FF3F8F};
  wire [7:0]   rdata;
  wire         sclk, cs_n, sdi, sdo, oe, srst, strict;
  int          fail_count = 0;
  int          total_checks = 0;
  int          cyc = 0;
  status_word_reporter DUT (.CLK_SYS(clk), .RESET_N(rst_n), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .SCLK(sclk),
    .CS_N(cs_n), .SDI(sdi), .SDO(sdo), .SDO_OE(oe), .FIFO_FULL(lv[5]),
    .FIFO_READ_DONE(lv[4]), .UPPER_LIMIT_EVENT(lv[3]),
    .LOWER_LIMIT_EVENT(lv[2]), .CONVERSION_FAULT(lv[1]),
    .ROM_INTEGRITY_FAIL(lv[0]), .ANALOG_POWERUP_EVT(ev[4]),
    .CHECKSUM_FAULT_EVT(ev[3]), .READONLY_WRITE_FAULT_EVT(ev[2]),
    .PARTIAL_ACCESS_EVT(ev[1]), .BAD_ADDRESS_EVT(ev[0]), .INIT_DONE(init),
    .SOFT_RESET(srst), .STRICT_ACCESS(strict));
  spi_host_model host (.SCLK(sclk), .CS_N(cs_n), .SDI(sdi), .SDO(sdo),
    .SDO_OE(oe));
  always #25 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      final_report();
    end
  end
  task final_report();
    if (fail_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
    end
  endtask
  task wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk({8'h00, rdata}, {8'h00, e});
  endtask
  task pulse(input logic [4:0] e);
    @(posedge clk);
    ev <= e;
    @(posedge clk);
    ev <= 5'h00;
  endtask
  task fr(input int n, input logic [15:0] e);
    host.frame(n, 16'hA5C3, w);
    chk(w, e);
  endtask
  task clr();
    wreg(8'h11, 8'hFF);
    wreg(8'h14, 8'h09);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rchk(8'h10, 8'h20);
    rchk(8'h01, 8'h00);
    rchk(8'h14, 8'h09);
    rchk(8'h7F, 8'h00);
    chk({15'h0000, strict}, 16'h0001);
    host.frame(16, 16'h0000, w);
    chk({15'h0000, host.oe_seen}, 16'h0000);
    rchk(8'h11, 8'h80);
    @(posedge clk) init <= 1'b1;
    wreg(8'h10, 8'h30);
    fr(16, 16'h00E0);
    rchk(8'h18, 8'hA5);
    rchk(8'h19, 8'hC3);
    clr();
    foreach (rows[i]) begin
      wreg(8'h01, {rows[i][27], 7'h00});
      lv <= rows[i][26:21];
      pulse(rows[i][20:16]);
      fr(rows[i][27] ? 8 : 16, rows[i][15:0]);
      @(posedge clk) lv <= 6'h00;
      clr();
    end
    host.frame(12, 16'h0000, w);
    fr(16, 16'h0010);
    clr();
    fork
      fr(16, 16'h0000);
      #240 @(posedge clk) lv <= 6'h20;
    join
    @(posedge clk) lv <= 6'h00;
    wreg(8'h10, 8'h31);
    @(negedge clk) chk({15'h0000, srst}, 16'h0001);
    @(negedge clk) chk({15'h0000, srst}, 16'h0000);
    rchk(8'h10, 8'h20);
    rchk(8'h14, 8'h09);
    wreg(8'h01, 8'h80);
    wreg(8'h10, 8'h10);
    pulse(5'h02);
    fr(8, 16'h0040);
    chk({15'h0000, strict}, 16'h0000);
    rchk(8'h18, 8'h00);
    rchk(8'h19, 8'hC3);
    @(posedge clk) rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rchk(8'h01, 8'h00);
    rchk(8'h10, 8'h20);
    rchk(8'h14, 8'h09);
    chk({15'h0000, strict}, 16'h0001);
    final_report();
  end
endmodule // spi_status_word_reporter_test
